// >>> core/cispc_pkg.sv
package cispc_pkg;

  // Register address and layout of the power-control register
  localparam logic [7:0] PWR_CTRL_ADDR = 8'h87;
  localparam logic [7:0] PWR_CTRL_RESET = 8'h00;
  localparam int IDLE_SEL_BIT = 0;
  localparam int STOP_SEL_BIT = 1;
  localparam int UART_STATUS1_BIT = 3;
  localparam int UART_BAUD_DOUBLE1_BIT = 4;
  localparam int UART_STATUS0_BIT = 6;
  localparam int UART_BAUD_DOUBLE0_BIT = 7;
  // Bits that hold plain storage (UART bits); the rest read zero
  localparam logic [7:0] PWR_CTRL_STORE_MASK = 8'hd8;

  // Reset vector that the core restarts at
  localparam logic [15:0] RESET_VECTOR = 16'h0000;

  // Missing-clock timeout in microseconds, and its cycle count
  localparam int DETECTOR_TIMEOUT_US = 100;
  localparam int CLK_MHZ = 20;
  localparam int DETECTOR_TIMEOUT_CYC = DETECTOR_TIMEOUT_US * CLK_MHZ;

  // Power modes
  typedef enum logic [1:0] {
    CISPC_RUN = 2'b00,
    CISPC_IDLE = 2'b01,
    CISPC_STOP = 2'b10
  } cispc_mode_e;

  // Special function register write/read port from the core
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic [7:0] addr;
    logic [7:0] wrData;
    logic instrDone;
  } cispc_sfr_s;

  // Gating outputs
  typedef struct packed {
    logic cpuHalt;
    logic periphClkEn;
    logic sysClkEn;
    logic oscEn;
  } cispc_gate_s;

endpackage

// >>> core/cispc_power_ctrl.sv
`timescale 1ns/10ps
module cispc_power_ctrl import cispc_pkg::*; (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Special function register port from the core
  input cispc_sfr_s sfr,
  output logic [7:0] sfrRdData,
  output logic sfrRdHit,
  // Wake and reset events
  input wire logic irqPending,
  input wire logic extResetPinN,
  input wire logic watchdogExpire,
  input wire logic missingClockDetectorExpire,
  // Gating and status outputs
  output cispc_gate_s gate,
  output logic coreResetReq,
  output logic [15:0] restartVector,
  output logic irqWake,
  output cispc_mode_e mode,
  output logic [7:0] uartCtrl
);

  // All module state in one struct
  typedef struct packed {
    cispc_mode_e mode;
    logic [7:0] store;
    logic armIdle;
    logic armStop;
    logic rstReq;
    logic wake;
    logic [7:0] rdData;
  } cispc_state_s;

  cispc_state_s st_r; // Registered state
  cispc_state_s st_nxt; // Next value of the state
  logic extResetPinSyncN; // Pin reset after two flops, still active low
  logic pwrWrite; // Core writes the power-control register this cycle
  logic anyReset; // Any reset source that ends a low-power mode

  // External reset pin crosses in from outside the clock domain
  // Stages start at the pin's idle high level, so no false pin reset follows resetn
  cispc_sync #(
    .WIDTH(1),
    .RESET_VAL(1'b1)
  ) uResetSync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .asyncIn(extResetPinN),
    .syncOut(extResetPinSyncN)
  );

  // Register decode
  assign pwrWrite = sfr.wrEn && (sfr.addr == PWR_CTRL_ADDR);
  // Internal or external reset sources
  // Watchdog and detector come from logic on this clock, so they need no sync
  assign anyReset = !extResetPinSyncN || watchdogExpire || missingClockDetectorExpire;

  // Next-state logic
  always_comb begin
    st_nxt = st_r;
    st_nxt.rstReq = 1'b0;
    st_nxt.wake = 1'b0;
    // Write stores UART bits; reserved and mode bits never stored
    if (pwrWrite) begin
      st_nxt.store = sfr.wrData & PWR_CTRL_STORE_MASK;
      // Only a one arms a mode; a zero does nothing
      if (sfr.wrData[STOP_SEL_BIT]) begin
        st_nxt.armStop = 1'b1;
      end else if (sfr.wrData[IDLE_SEL_BIT]) begin
        st_nxt.armIdle = 1'b1;
      end
    end
    // Read data: mode bits read zero
    st_nxt.rdData = st_r.store & PWR_CTRL_STORE_MASK;
    case (st_r.mode)
      CISPC_RUN: begin
        // Entry waits until the writing instruction completes
        if (sfr.instrDone && (st_r.armStop || st_nxt.armStop)) begin
          st_nxt.mode = CISPC_STOP;
          st_nxt.armStop = 1'b0;
          st_nxt.armIdle = 1'b0;
        end else if (sfr.instrDone && (st_r.armIdle || st_nxt.armIdle)) begin
          st_nxt.mode = CISPC_IDLE;
          st_nxt.armIdle = 1'b0;
        end
      end
      CISPC_IDLE: begin
        // Reset outranks interrupt wake
        if (anyReset) begin
          st_nxt.mode = CISPC_RUN;
          st_nxt.rstReq = 1'b1;
        end else if (irqPending) begin
          // Core resumes and takes the interrupt; its return address is the
          // instruction after the idle write, kept by the core's own PC
          st_nxt.mode = CISPC_RUN;
          st_nxt.wake = 1'b1;
        end
      end
      CISPC_STOP: begin
        // Interrupts ignored; only a reset restarts the oscillator
        if (anyReset) begin
          st_nxt.mode = CISPC_RUN;
          st_nxt.rstReq = 1'b1;
        end
      end
      default: begin
        st_nxt.mode = CISPC_RUN;
      end
    endcase
  end

  // State register; the register itself resets to zero
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '{mode: CISPC_RUN, store: PWR_CTRL_RESET, armIdle: 1'b0, armStop: 1'b0,
                rstReq: 1'b0, wake: 1'b0, rdData: 8'h00};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Gating: idle holds only the CPU, so its state is frozen but kept
  always_comb begin
    gate.cpuHalt = (st_r.mode != CISPC_RUN);
    gate.periphClkEn = (st_r.mode != CISPC_STOP);
    gate.sysClkEn = (st_r.mode != CISPC_STOP);
    gate.oscEn = (st_r.mode != CISPC_STOP);
  end

  // Outputs from flops; sfrRdHit is decoded from the port, restartVector is a constant
  assign sfrRdData = st_r.rdData;
  assign sfrRdHit = sfr.rdEn && (sfr.addr == PWR_CTRL_ADDR);
  assign coreResetReq = st_r.rstReq;
  assign restartVector = RESET_VECTOR;
  assign irqWake = st_r.wake;
  assign mode = st_r.mode;
  assign uartCtrl = st_r.store;

  // Assertions

  // Only a reset may take the part out of stop
  a_stop_only_reset: assert property (@(posedge sys_clk) disable iff (!resetn)
    (st_r.mode == CISPC_STOP && !anyReset) |=> (st_r.mode == CISPC_STOP))
    else $error("stop left without reset");

  // A pending interrupt in idle resumes the core on the next edge
  a_idle_irq_wake: assert property (@(posedge sys_clk) disable iff (!resetn)
    (st_r.mode == CISPC_IDLE && irqPending && !anyReset) |=> irqWake && !gate.cpuHalt)
    else $error("interrupt did not wake idle");

  // Idle holds only the core; clocks and peripherals keep running
  a_idle_clocks_run: assert property (@(posedge sys_clk) disable iff (!resetn)
    (mode == CISPC_IDLE) |-> gate.cpuHalt && gate.sysClkEn && gate.periphClkEn)
    else $error("idle gating wrong");

  // Stop halts the core, the clock, the oscillator and the peripheral clocks
  a_stop_clocks_off: assert property (@(posedge sys_clk) disable iff (!resetn)
    (mode == CISPC_STOP) |-> gate.cpuHalt && !gate.sysClkEn && !gate.oscEn
    && !gate.periphClkEn)
    else $error("stop gating wrong");

  // An idle write enters idle once its instruction completes
  a_idle_entry: assert property (@(posedge sys_clk) disable iff (!resetn)
    (mode == CISPC_RUN && pwrWrite && sfr.wrData[1:0] == 2'b01 && sfr.instrDone)
    |=> mode == CISPC_IDLE)
    else $error("idle not entered");

  // A stop write enters stop once its instruction completes
  a_stop_entry: assert property (@(posedge sys_clk) disable iff (!resetn)
    (mode == CISPC_RUN && pwrWrite && sfr.wrData[STOP_SEL_BIT] && sfr.instrDone)
    |=> mode == CISPC_STOP)
    else $error("stop not entered");

  // A watchdog reset ends either low-power mode
  a_reset_exit: assert property (@(posedge sys_clk) disable iff (!resetn)
    (mode != CISPC_RUN && watchdogExpire) |=> coreResetReq && mode == CISPC_RUN)
    else $error("reset did not end low power");

  // Mode and reserved bits never read back
  a_mode_bits_zero: assert property (@(posedge sys_clk) disable iff (!resetn)
    sfrRdData[1:0] == 2'b00 && sfrRdData[5] == 1'b0 && sfrRdData[2] == 1'b0)
    else $error("mode or reserved bits read nonzero");

  // A write with both mode bits clear leaves the part running
  a_zero_write_noop: assert property (@(posedge sys_clk) disable iff (!resetn)
    (mode == CISPC_RUN && pwrWrite && sfr.wrData[1:0] == 2'b00 && !st_r.armIdle
     && !st_r.armStop) |=> mode == CISPC_RUN)
    else $error("zero write changed mode");

  // An interrupt is ignored in stop and raises no wake pulse
  a_stop_irq_ignored: assert property (@(posedge sys_clk) disable iff (!resetn)
    (mode == CISPC_STOP && irqPending && !anyReset) |=> mode == CISPC_STOP && !irqWake)
    else $error("interrupt acted in stop");

  // The detector's reset ends stop and asks for a core reset
  a_detector_exit: assert property (@(posedge sys_clk) disable iff (!resetn)
    (mode == CISPC_STOP && missingClockDetectorExpire) |=> coreResetReq && mode == CISPC_RUN)
    else $error("detector reset did not end stop");

  // The stored bits hold still through idle unless the core writes them
  a_store_kept_idle: assert property (@(posedge sys_clk) disable iff (!resetn)
    (mode == CISPC_IDLE && !pwrWrite) |=> $stable(uartCtrl))
    else $error("register changed in idle");

  // The wake request is a single-cycle pulse
  a_wake_pulse_once: assert property (@(posedge sys_clk) disable iff (!resetn)
    irqWake |=> !irqWake)
    else $error("wake pulse too long");

  // The core reset request is a single-cycle pulse
  a_reset_pulse_once: assert property (@(posedge sys_clk) disable iff (!resetn)
    coreResetReq |=> !coreResetReq)
    else $error("reset request pulse too long");

endmodule

// >>> core/cispc_sync.sv
`timescale 1ns/10ps
// Two-stage synchroniser for pin-level inputs
module cispc_sync import cispc_pkg::*; #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Data
  input wire logic [WIDTH-1:0] asyncIn,
  output logic [WIDTH-1:0] syncOut
);

  // Both stages in one state word; stage one is read only by stage two
  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } cispc_sync_s;

  cispc_sync_s st_r; // Registered stages
  cispc_sync_s st_nxt; // Next value of both stages

  // Shift the input one stage along per clock
  always_comb begin
    st_nxt.stage1 = asyncIn;
    st_nxt.stage2 = st_r.stage1;
  end

  // Stages start at the input's idle level, so release of reset shows no false edge
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= '{stage1: RESET_VAL, stage2: RESET_VAL};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Only the second stage is seen outside
  assign syncOut = st_r.stage2;

endmodule

// >>> verif/cispc_core_model.sv
`timescale 1ns/10ps
// Behavioural core: each write it issues is the last act of its instruction
module cispc_core_model import cispc_pkg::*; (
  // Request from the bench
  input wire logic reqWr,
  input wire logic [7:0] reqAddr,
  input wire logic [7:0] reqData,
  // Port into the block
  output cispc_sfr_s sfr
);
  // Write retires its instruction in the same cycle; reads follow the bench's address
  always_comb begin
    sfr.wrEn = reqWr;
    sfr.rdEn = 1'b1;
    sfr.addr = reqAddr;
    // Idle data bus carries the inverse, so stale data is never mistaken for a write
    sfr.wrData = reqWr ? reqData : ~reqData;
    sfr.instrDone = reqWr;
  end
endmodule

// >>> verif/cpu_idle_stop_power_control_tb.sv
`timescale 1ns/10ps
module cpu_idle_stop_power_control_tb;
  import cispc_pkg::*;
  logic sys_clk, resetn, reqWr, irqPending, extResetPinN, watchdogExpire;
  logic missingClockDetectorExpire;
  logic [7:0] reqData, sfrRdData, uartCtrl, d, reqAddr;
  logic [15:0] restartVector;
  logic sfrRdHit, coreResetReq, irqWake;
  logic [31:0] seed;
  cispc_sfr_s sfr;
  cispc_gate_s gate;
  cispc_mode_e mode;
  int nMismatch, comparisons, cyc, expM;

  cispc_core_model core (.reqWr(reqWr), .reqAddr(reqAddr), .reqData(reqData), .sfr(sfr));
  cispc_power_ctrl dut (.sys_clk(sys_clk), .resetn(resetn), .sfr(sfr), .sfrRdData(sfrRdData),
    .sfrRdHit(sfrRdHit), .irqPending(irqPending), .extResetPinN(extResetPinN),
    .watchdogExpire(watchdogExpire), .missingClockDetectorExpire(missingClockDetectorExpire),
    .gate(gate), .coreResetReq(coreResetReq), .restartVector(restartVector),
    .irqWake(irqWake), .mode(mode), .uartCtrl(uartCtrl));

  // Clock of 50 ns period
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Hang guard: the run needs well under 1000 cycles
  initial begin
    cyc = 0;
    forever begin
      @(posedge sys_clk);
      cyc++;
      if (cyc > 3000) begin
        nMismatch++;
        testDone();
      end
    end
  end

  // Fixed-seed xorshift source
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    comparisons++;
    if (seen !== exp) begin
      nMismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Inputs always move 1 ns after the rising edge
  task automatic step();
    @(posedge sys_clk);
    #1;
  endtask

  task automatic testDone();
    $display("mismatches=%0d comparisons=%0d", nMismatch, comparisons);
    if (nMismatch == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    nMismatch = 0;
    comparisons = 0;
    seed = 32'h2c93;
    {reqWr, irqPending, watchdogExpire, missingClockDetectorExpire} = 4'h0;
    reqData = 8'h00;
    reqAddr = PWR_CTRL_ADDR;
    extResetPinN = 1'b1;
    resetn = 1'b0;
    repeat (8) @(posedge sys_clk);
    #1 resetn = 1'b1;
    step();
    chk(sfrRdData, 8'h00);
    chk({sfrRdHit, mode}, {1'b1, CISPC_RUN});
    // A write elsewhere in the register space must not touch the block
    reqAddr = 8'h86;
    reqData = 8'hff;
    reqWr = 1'b1;
    step();
    reqWr = 1'b0;
    chk({sfrRdHit, mode}, {1'b0, CISPC_RUN});
    step();
    chk(sfrRdData, 8'h00);
    chk(uartCtrl, 8'h00);
    reqAddr = PWR_CTRL_ADDR;
    for (int i = 0; i < 24; i++) begin
      seed = xs(seed);
      d = seed[7:0];
      // Mode bits walk through all four codes so every exit path is reached except pin reset from stop and detector from idle
      d[1:0] = 2'(i % 4);
      // Stop wins over idle when both bits are set
      expM = d[1] ? 2 : (d[0] ? 1 : 0);
      reqWr = 1'b1;
      reqData = d;
      step();
      reqWr = 1'b0;
      chk(mode, expM);
      chk(gate, expM == 2 ? 4'h8 : (expM == 1 ? 4'hf : 4'h7));
      step();
      chk(sfrRdData, d & 8'hd8);
      chk(uartCtrl, d & 8'hd8);
      if (expM == 1) begin
        if (i % 3 == 0) begin
          // Pin reset passes two sync flops before the exit
          extResetPinN = 1'b0;
          repeat (3) step();
          chk({coreResetReq, restartVector, mode}, {1'b1, RESET_VECTOR, CISPC_RUN});
          extResetPinN = 1'b1;
          repeat (4) step();
        end else if (i % 3 == 1) begin
          watchdogExpire = 1'b1;
          step();
          chk({coreResetReq, restartVector, mode}, {1'b1, RESET_VECTOR, CISPC_RUN});
          watchdogExpire = 1'b0;
        end else begin
          irqPending = 1'b1;
          step();
          chk({irqWake, coreResetReq, mode}, {2'b10, CISPC_RUN});
          irqPending = 1'b0;
        end
      end else if (expM == 2) begin
        // An interrupt must not wake the stopped part
        irqPending = 1'b1;
        step();
        chk({irqWake, mode}, {1'b0, CISPC_STOP});
        irqPending = 1'b0;
        missingClockDetectorExpire = i[0];
        watchdogExpire = ~i[0];
        step();
        chk({coreResetReq, restartVector, mode}, {1'b1, RESET_VECTOR, CISPC_RUN});
        {watchdogExpire, missingClockDetectorExpire} = 2'b00;
      end
      step();
    end
    testDone();
  end
endmodule
